// ===== src/spb_pkg.sv
// shared constants of the segmented packet bus interface
package spb_pkg;

    // ************
    // bus geometry
    // ************
    localparam int SEG_NUM   = 4;
    localparam int SEG_W     = 128;
    localparam int BYTE_W    = 8;
    localparam int SEG_BYTES = SEG_W / BYTE_W;
    localparam int MTY_W     = 4;
    localparam int SEG_IDX_W = 2;

    // ************
    // stored word layout of the transmit buffer
    // ************
    localparam int WRD_DATA_LSB = 0;
    localparam int WRD_MTY_LSB  = SEG_W;
    localparam int WRD_EOP_BIT  = SEG_W + MTY_W;
    localparam int WRD_SOP_BIT  = SEG_W + MTY_W + 1;
    localparam int WRD_W        = SEG_W + MTY_W + 2;

    // ************
    // backpressure and buffering
    // ************
    localparam int SAFE_WRITES  = 8;
    localparam int OVF_LIMIT    = 11;
    localparam int OVF_CNT_W    = 4;
    localparam int TX_DEPTH     = 1024;
    // ready falls one write cycle too late for the overflow limit to fit; up to 4 words overrun
    localparam int RDY_MARGIN   = (OVF_LIMIT + 1) * SEG_NUM;

    // ************
    // frame length limits
    // ************
    localparam int MIN_LEN      = 64;
    localparam int MAX_LEN      = 9216;
    localparam int WCNT_W       = 12;
    localparam int LEN_W        = 16;
    localparam int MAX_PKT_WRDS = (MAX_LEN + SEG_BYTES - 1) / SEG_BYTES;

    // ************
    // reset values and masks
    // ************
    localparam logic             TX_RDY_RST   = 1'b0;
    localparam logic [MTY_W-1:0] MTY_ERR_MASK = 4'h7;

    typedef enum logic [0:0] {
        SPB_RX_IDLE = 1'b0,
        SPB_RX_BUSY = 1'b1
    } spb_rx_state_e;

endpackage : spb_pkg

// ===== src/spb_tx_place.sv
// per-segment write placement and drop rewind for the transmit buffer
`timescale 1ns/1ns
module spb_tx_place #(
    parameter int SEG_NUM = spb_pkg::SEG_NUM,
    parameter int AW      = 11
) (
    input  wire logic [SEG_NUM-1:0]    ena_i,
    input  wire logic [SEG_NUM-1:0]    eop_i,
    input  wire logic [SEG_NUM-1:0]    err_i,
    input  wire logic                  block_i,
    input  wire logic [AW-1:0]         wr_ptr_i,
    input  wire logic [AW-1:0]         commit_ptr_i,
    output logic      [SEG_NUM-1:0]    we_o,
    output logic      [SEG_NUM*AW-1:0] addr_o,
    output logic      [AW-1:0]         next_wr_o,
    output logic      [AW-1:0]         next_commit_o
);

    logic [AW-1:0] pos [0:SEG_NUM];
    logic [AW-1:0] com [0:SEG_NUM];

    assign pos[0] = wr_ptr_i;
    assign com[0] = commit_ptr_i;

    genvar k;
    generate
        for (k = 0; k < SEG_NUM; k++) begin : g_seg
            wire logic take;
            wire logic drop;
            wire logic done;
            assign take = ena_i[k] & ~block_i;
            assign drop = take & eop_i[k] & err_i[k];
            assign done = take & eop_i[k] & ~err_i[k];
            assign we_o[k] = take;
            assign addr_o[k*AW +: AW] = pos[k];
            assign pos[k+1] = drop ? com[k] :
                              take ? pos[k] + AW'(1) : pos[k];
            assign com[k+1] = done ? pos[k] + AW'(1) : com[k];
        end
    endgenerate

    assign next_wr_o     = pos[SEG_NUM];
    assign next_commit_o = com[SEG_NUM];

endmodule : spb_tx_place

// ===== src/spb_rx_len.sv
// receive frame tracker: length window and error collection
`timescale 1ns/1ns
module spb_rx_len (
    input  wire logic                     clk_i,
    input  wire logic                     sys_rst_i,
    input  wire logic                     valid_i,
    input  wire logic                     sop_i,
    input  wire logic                     eop_i,
    input  wire logic [spb_pkg::MTY_W-1:0] mty_i,
    input  wire logic                     code_bad_i,
    input  wire logic                     fcs_bad_i,
    output logic                          acc_o,
    output logic                          sop_o,
    output logic                          err_o
);

    spb_pkg::spb_rx_state_e          state;
    logic [spb_pkg::WCNT_W-1:0]      wcnt;
    logic                            bad_seen;

    wire logic                       busy;
    wire logic                       stray;
    wire logic [spb_pkg::WCNT_W-1:0] cur_wrds;
    wire logic [spb_pkg::LEN_W-1:0]  bytes;
    wire logic                       bad_now;
    wire logic                       len_bad;

    assign busy  = (state == spb_pkg::SPB_RX_BUSY);
    // words outside a frame are discarded, never shown to the user
    assign acc_o = valid_i & (sop_i | busy);
    assign sop_o = sop_i & ~busy;
    // a start inside an open frame is merged and the frame failed
    assign stray = sop_i & busy;
    assign cur_wrds = sop_o ? spb_pkg::WCNT_W'(1) :
                      (&wcnt) ? wcnt : wcnt + spb_pkg::WCNT_W'(1);
    assign bytes = spb_pkg::LEN_W'(cur_wrds) *
                   spb_pkg::LEN_W'(spb_pkg::SEG_BYTES) -
                   spb_pkg::LEN_W'(mty_i);
    assign bad_now = code_bad_i | stray | (bad_seen & ~sop_o);
    assign len_bad = (bytes < spb_pkg::LEN_W'(spb_pkg::MIN_LEN)) |
                     (bytes > spb_pkg::LEN_W'(spb_pkg::MAX_LEN)) |
                     (&wcnt);
    assign err_o = eop_i & (bad_now | fcs_bad_i | len_bad);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state    <= spb_pkg::SPB_RX_IDLE;
            wcnt     <= '0;
            bad_seen <= 1'b0;
        end else if (acc_o) begin
            case (eop_i)
                1'b1: begin
                    state    <= spb_pkg::SPB_RX_IDLE;
                    wcnt     <= '0;
                    bad_seen <= 1'b0;
                end
                default: begin
                    state    <= spb_pkg::SPB_RX_BUSY;
                    wcnt     <= cur_wrds;
                    bad_seen <= bad_now;
                end
            endcase
        end
    end

endmodule : spb_rx_len

// ===== src/spb_bus_if.sv
// segmented packet bus: transmit buffer with backpressure, receive packer
`timescale 1ns/1ns
module spb_bus_if #(
    parameter int TX_DEPTH = spb_pkg::TX_DEPTH
) (
    input  wire logic                                    clk_i,
    input  wire logic                                    sys_rst_i,
    // transmit segmented bus from user logic
    input  wire logic [spb_pkg::SEG_NUM*spb_pkg::SEG_W-1:0] tx_data_i,
    input  wire logic [spb_pkg::SEG_NUM-1:0]             tx_ena_i,
    input  wire logic [spb_pkg::SEG_NUM-1:0]             tx_sop_i,
    input  wire logic [spb_pkg::SEG_NUM-1:0]             tx_eop_i,
    input  wire logic [spb_pkg::SEG_NUM-1:0]             tx_err_i,
    input  wire logic [spb_pkg::SEG_NUM*spb_pkg::MTY_W-1:0] tx_mty_i,
    output logic                                         tx_rdy_o,
    output logic                                         tx_ovf_o,
    // transmit word stream toward the line
    output logic                                         ln_tx_valid_o,
    output logic [spb_pkg::SEG_W-1:0]                    ln_tx_data_o,
    output logic                                         ln_tx_sop_o,
    output logic                                         ln_tx_eop_o,
    output logic [spb_pkg::MTY_W-1:0]                    ln_tx_mty_o,
    input  wire logic                                    ln_tx_ready_i,
    // receive word stream from the line
    input  wire logic                                    ln_rx_valid_i,
    input  wire logic [spb_pkg::SEG_W-1:0]               ln_rx_data_i,
    input  wire logic                                    ln_rx_sop_i,
    input  wire logic                                    ln_rx_eop_i,
    input  wire logic [spb_pkg::MTY_W-1:0]               ln_rx_mty_i,
    input  wire logic                                    ln_rx_code_bad_i,
    input  wire logic                                    ln_rx_fcs_bad_i,
    // receive segmented bus toward user logic
    output logic [spb_pkg::SEG_NUM*spb_pkg::SEG_W-1:0]   rx_data_o,
    output logic [spb_pkg::SEG_NUM-1:0]                  rx_ena_o,
    output logic [spb_pkg::SEG_NUM-1:0]                  rx_sop_o,
    output logic [spb_pkg::SEG_NUM-1:0]                  rx_eop_o,
    output logic [spb_pkg::SEG_NUM-1:0]                  rx_err_o,
    output logic [spb_pkg::SEG_NUM*spb_pkg::MTY_W-1:0]   rx_mty_o
);

    localparam int SN = spb_pkg::SEG_NUM;
    localparam int SW = spb_pkg::SEG_W;
    localparam int MW = spb_pkg::MTY_W;
    localparam int WW = spb_pkg::WRD_W;
    localparam int IW = $clog2(TX_DEPTH);
    localparam int AW = IW + 1;

    // ************
    // parameter checks
    // ************
    generate
        if ((TX_DEPTH & (TX_DEPTH - 1)) != 0) begin : g_chk_pow2
            $error("transmit buffer depth must be a power of two");
        end
        if (TX_DEPTH < spb_pkg::MAX_PKT_WRDS + spb_pkg::RDY_MARGIN)
        begin : g_chk_depth
            $error("transmit buffer cannot hold a largest frame");
        end
    endgenerate

    // ************
    // transmit buffer
    // ************
    // store-and-forward: only committed packets leave, so a dropped
    // packet never reaches the line; costs one frame of latency
    logic [WW-1:0]      tx_mem [0:TX_DEPTH-1];
    logic [AW-1:0]      wr_ptr;
    logic [AW-1:0]      commit_ptr;
    logic [AW-1:0]      rd_ptr;
    logic [spb_pkg::OVF_CNT_W-1:0] late_cnt;

    wire logic [SN-1:0]    seg_we;
    wire logic [SN*AW-1:0] seg_addr;
    wire logic [AW-1:0]    next_wr;
    wire logic [AW-1:0]    next_commit;
    wire logic [AW-1:0]    fill;
    wire logic [AW-1:0]    free;
    wire logic             next_rdy;
    wire logic             wr_cycle;
    wire logic             late_wr;
    wire logic             rd_take;
    wire logic [WW-1:0]    rd_word;

    spb_tx_place #(
        .SEG_NUM (SN),
        .AW      (AW)
    ) u_place (
        .ena_i         (tx_ena_i),
        .eop_i         (tx_eop_i),
        .err_i         (tx_err_i),
        .block_i       (tx_ovf_o),
        .wr_ptr_i      (wr_ptr),
        .commit_ptr_i  (commit_ptr),
        .we_o          (seg_we),
        .addr_o        (seg_addr),
        .next_wr_o     (next_wr),
        .next_commit_o (next_commit)
    );

    assign fill = wr_ptr - rd_ptr;
    assign free = AW'(TX_DEPTH) - fill;
    // ready leaves room for late writes
    assign next_rdy = (free >= AW'(spb_pkg::RDY_MARGIN)) & ~tx_ovf_o;
    assign wr_cycle = |tx_ena_i;
    assign late_wr  = wr_cycle & ~tx_rdy_o & ~tx_ovf_o;

    always_ff @(posedge clk_i) begin
        for (int k = 0; k < SN; k++) begin
            if (seg_we[k]) begin
                tx_mem[seg_addr[k*AW +: IW]] <= {tx_sop_i[k],
                                                 tx_eop_i[k],
                                                 tx_mty_i[k*MW +: MW],
                                                 tx_data_i[k*SW +: SW]};
            end
        end
    end

    // all launch and capture on rising edge
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_ptr     <= '0;
            commit_ptr <= '0;
        end else begin
            wr_ptr     <= next_wr;
            commit_ptr <= next_commit;
        end
    end

    // ************
    // backpressure and overflow
    // ************
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_rdy_o <= spb_pkg::TX_RDY_RST;
            late_cnt <= '0;
            tx_ovf_o <= 1'b0;
        end else begin
            tx_rdy_o <= next_rdy;
            if (tx_rdy_o) begin
                late_cnt <= '0;
            end else if (late_wr) begin
                late_cnt <= late_cnt + spb_pkg::OVF_CNT_W'(1);
            end
            if (late_wr && late_cnt ==
                    spb_pkg::OVF_CNT_W'(spb_pkg::OVF_LIMIT - 1)) begin
                tx_ovf_o <= 1'b1;
            end
        end
    end

    // ************
    // drain toward the line
    // ************
    assign rd_take = (rd_ptr != commit_ptr) &
                     (~ln_tx_valid_o | ln_tx_ready_i);
    assign rd_word = tx_mem[rd_ptr[IW-1:0]];

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_ptr        <= '0;
            ln_tx_valid_o <= 1'b0;
            ln_tx_data_o  <= '0;
            ln_tx_sop_o   <= 1'b0;
            ln_tx_eop_o   <= 1'b0;
            ln_tx_mty_o   <= '0;
        end else if (rd_take) begin
            rd_ptr        <= rd_ptr + AW'(1);
            ln_tx_valid_o <= 1'b1;
            ln_tx_data_o  <= rd_word[spb_pkg::WRD_DATA_LSB +: SW];
            ln_tx_sop_o   <= rd_word[spb_pkg::WRD_SOP_BIT];
            ln_tx_eop_o   <= rd_word[spb_pkg::WRD_EOP_BIT];
            // empty count only kept on end word
            ln_tx_mty_o   <= rd_word[spb_pkg::WRD_EOP_BIT] ?
                             rd_word[spb_pkg::WRD_MTY_LSB +: MW] : '0;
        end else if (ln_tx_ready_i) begin
            ln_tx_valid_o <= 1'b0;
        end
    end

    // ************
    // receive frame check
    // ************
    wire logic rx_acc;
    wire logic rx_sop_fix;
    wire logic rx_err_now;

    spb_rx_len u_rx_len (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .valid_i    (ln_rx_valid_i),
        .sop_i      (ln_rx_sop_i),
        .eop_i      (ln_rx_eop_i),
        .mty_i      (ln_rx_mty_i),
        .code_bad_i (ln_rx_code_bad_i),
        .fcs_bad_i  (ln_rx_fcs_bad_i),
        .acc_o      (rx_acc),
        .sop_o      (rx_sop_fix),
        .err_o      (rx_err_now)
    );

    // ************
    // receive packer
    // ************
    // a cycle leaves when full or at frame end, so no segment gaps
    logic [spb_pkg::SEG_IDX_W-1:0] slot_cnt;
    logic [SW-1:0]                 slot_data [0:SN-2];
    logic [SN-2:0]                 slot_sop;

    wire logic             take_w;
    wire logic             emit;
    wire logic [MW-1:0]    eop_mty;
    wire logic [SN*SW-1:0] emit_data;
    wire logic [SN-1:0]    emit_ena;
    wire logic [SN-1:0]    emit_sop;
    wire logic [SN-1:0]    emit_eop;
    wire logic [SN-1:0]    emit_err;
    wire logic [SN*MW-1:0] emit_mty;

    assign take_w = ln_rx_valid_i & rx_acc;
    // output held back until a cycle fills or the frame ends
    assign emit = take_w & (ln_rx_eop_i |
                  (slot_cnt == spb_pkg::SEG_IDX_W'(SN - 1)));
    // low bytes blanked; error forces low bits clear
    assign eop_mty = rx_err_now ? (ln_rx_mty_i & ~spb_pkg::MTY_ERR_MASK)
                                : ln_rx_mty_i;

    genvar g;
    generate
        for (g = 0; g < SN; g++) begin : g_emit
            wire logic here;
            assign here = (slot_cnt == spb_pkg::SEG_IDX_W'(g));
            // segments 0 through the last word
            assign emit_ena[g] = emit &
                                 (slot_cnt >= spb_pkg::SEG_IDX_W'(g));
            // end word carries error and empty count
            assign emit_eop[g] = here & ln_rx_eop_i;
            assign emit_err[g] = here & ln_rx_eop_i & rx_err_now;
            assign emit_mty[g*MW +: MW] = (here & ln_rx_eop_i) ?
                                          eop_mty : '0;
            if (g < SN - 1) begin : g_slot
                assign emit_data[g*SW +: SW] = here ? ln_rx_data_i
                                                    : slot_data[g];
                assign emit_sop[g] = here ? rx_sop_fix : slot_sop[g];
                always_ff @(posedge clk_i) begin
                    if (take_w && !emit && here) begin
                        slot_data[g] <= ln_rx_data_i;
                    end
                end
            end else begin : g_last
                assign emit_data[g*SW +: SW] = ln_rx_data_i;
                assign emit_sop[g] = rx_sop_fix;
            end
        end
    endgenerate

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            slot_cnt <= '0;
            slot_sop <= '0;
        end else if (take_w) begin
            if (emit) begin
                slot_cnt <= '0;
            end else begin
                slot_cnt <= slot_cnt + spb_pkg::SEG_IDX_W'(1);
                slot_sop[slot_cnt] <= rx_sop_fix;
            end
        end
    end

    // output pushed every cycle, no stall
    // only legal cycles are emitted, partial ones only at frame end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_data_o <= '0;
            rx_ena_o  <= '0;
            rx_sop_o  <= '0;
            rx_eop_o  <= '0;
            rx_err_o  <= '0;
            rx_mty_o  <= '0;
        end else if (emit) begin
            rx_data_o <= emit_data;
            rx_ena_o  <= emit_ena;
            rx_sop_o  <= emit_sop & emit_ena;
            rx_eop_o  <= emit_eop;
            rx_err_o  <= emit_err;
            rx_mty_o  <= emit_mty;
        end else begin
            rx_data_o <= '0;
            rx_ena_o  <= '0;
            rx_sop_o  <= '0;
            rx_eop_o  <= '0;
            rx_err_o  <= '0;
            rx_mty_o  <= '0;
        end
    end

endmodule : spb_bus_if

// ===== dv/spb_properties.sv
// port checker of the segmented packet bus block
`timescale 1ns/1ns
module spb_props (
    input wire logic         clk_i,
    input wire logic         sys_rst_i,
    input wire logic [3:0]   tx_ena_i,
    input wire logic         tx_rdy_o,
    input wire logic         tx_ovf_o,
    input wire logic         ln_tx_valid_o,
    input wire logic [127:0] ln_tx_data_o,
    input wire logic         ln_tx_eop_o,
    input wire logic [3:0]   ln_tx_mty_o,
    input wire logic         ln_tx_ready_i,
    input wire logic [3:0]   rx_ena_o,
    input wire logic [3:0]   rx_sop_o,
    input wire logic [3:0]   rx_eop_o,
    input wire logic [3:0]   rx_err_o,
    input wire logic [15:0]  rx_mty_o
);
    // ************
    // late writes: counted while ready is low, cleared while high
    // ************
    logic [3:0] late_cnt;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) late_cnt <= 4'h0;
        else if (tx_rdy_o) late_cnt <= 4'h0;
        else if (|tx_ena_i && late_cnt != 4'hf) late_cnt <= late_cnt + 4'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_ovf_set; !tx_ovf_o ##1 tx_ovf_o; endsequence
    property p_ovf_cause; s_ovf_set |-> late_cnt >= 4'hb; endproperty
    property p_ovf_due; late_cnt == 4'hb |-> ##[0:1] tx_ovf_o; endproperty
    property p_ovf_keep; tx_ovf_o |=> tx_ovf_o; endproperty
    property p_rx_qual; (~rx_ena_o & (rx_sop_o | rx_eop_o | rx_err_o)) == 0;
    endproperty
    property p_rx_seg0; rx_ena_o != 4'h0 |-> rx_ena_o[0]; endproperty
    property p_rx_contig; rx_ena_o inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
    endproperty
    property p_rx_gap; (rx_eop_o[2:0] & rx_ena_o[3:1]) == 3'h0; endproperty
    property p_rx_mty; rx_err_o[0] |-> rx_mty_o[2:0] == 3'h0; endproperty
    property p_ln_hold; ln_tx_valid_o && !ln_tx_ready_i |=>
        ln_tx_valid_o && $stable(ln_tx_data_o); endproperty
    property p_ln_mty; ln_tx_valid_o && !ln_tx_eop_o |-> ln_tx_mty_o == 0;
    endproperty
    a_ovf_cause: assert property (p_ovf_cause)
        else $error("overflow before eleven late writes");
    a_ovf_due: assert property (p_ovf_due)
        else $error("no overflow after eleven late writes");
    a_ovf_keep: assert property (p_ovf_keep)
        else $error("overflow cleared without reset");
    a_rx_qual: assert property (p_rx_qual)
        else $error("receive flag on disabled segment");
    a_rx_seg0: assert property (p_rx_seg0)
        else $error("receive cycle without segment zero");
    a_rx_contig: assert property (p_rx_contig)
        else $error("receive segments not contiguous");
    a_rx_gap: assert property (p_rx_gap)
        else $error("receive segment after packet end");
    a_rx_mty: assert property (p_rx_mty)
        else $error("errored end with low empty bits set");
    a_ln_hold: assert property (p_ln_hold)
        else $error("line word changed while stalled");
    a_ln_mty: assert property (p_ln_mty)
        else $error("empty count on a non-end line word");
endmodule : spb_props

// ===== dv/spb_line_model.sv
// line side model: takes transmit words, sends receive words
`timescale 1ns/1ns
module spb_line_model (
    input  wire logic         clk_i,
    input  wire logic         stall_i,
    input  wire logic         valid_i,
    input  wire logic [127:0] data_i,
    input  wire logic         sop_i,
    input  wire logic         eop_i,
    input  wire logic [3:0]   mty_i,
    output logic              ready_o,
    output logic              rx_valid_o,
    output logic [127:0]      rx_data_o,
    output logic              rx_sop_o,
    output logic              rx_eop_o,
    output logic [3:0]        rx_mty_o,
    output logic              rx_code_bad_o,
    output logic              rx_fcs_bad_o
);
    // ************
    // word exchange
    // ************
    int           taken = 0;
    logic [133:0] last = '0;
    assign ready_o = !stall_i;
    initial begin
        {rx_valid_o, rx_data_o, rx_sop_o, rx_eop_o} = '0;
        {rx_mty_o, rx_code_bad_o, rx_fcs_bad_o} = '0;
    end
    // words taken on the rising edge only
    always @(posedge clk_i) begin
        if (valid_i && ready_o) begin
            taken <= taken + 1;
            last <= {sop_i, eop_i, mty_i, data_i};
        end
    end
    task automatic send(input logic [127:0] d, input logic s, input logic e,
                        input logic [3:0] m, input logic [1:0] bad);
        {rx_valid_o, rx_data_o, rx_sop_o, rx_eop_o} = {1'b1, d, s, e};
        {rx_mty_o, rx_code_bad_o, rx_fcs_bad_o} = {m, bad};
        @(posedge clk_i);
        #1;
    endtask : send
    // released data shows the inverse, never a stale copy
    task automatic idle();
        {rx_valid_o, rx_data_o, rx_sop_o, rx_eop_o} = {1'b0, ~rx_data_o, 2'b0};
        {rx_mty_o, rx_code_bad_o, rx_fcs_bad_o} = '0;
    endtask : idle
endmodule : spb_line_model

// ===== dv/tb_top.sv
// testbench of the segmented packet bus block
`timescale 1ns/1ns
module tb_top;
    // ************
    // signals and instances
    // ************
    localparam logic [127:0] P = 128'h000102030405060708090a0b0c0d0e0f;
    logic         clk_i = 1'b0;
    logic         sys_rst_i = 1'b1;
    logic [511:0] tx_data_i = {4{P}};
    logic [3:0]   tx_ena_i = 4'h0, tx_sop_i = 4'h0, tx_eop_i = 4'h0;
    logic [3:0]   tx_err_i = 4'h0;
    logic [15:0]  tx_mty_i = 16'h0;
    logic         tx_rdy_o, tx_ovf_o, ln_tx_valid_o, ln_tx_sop_o, ln_tx_eop_o;
    logic [127:0] ln_tx_data_o, ln_rx_data_i;
    logic [3:0]   ln_tx_mty_o, ln_rx_mty_i;
    logic         ln_tx_ready_i, ln_rx_valid_i, ln_rx_sop_i, ln_rx_eop_i;
    logic         ln_rx_code_bad_i, ln_rx_fcs_bad_i, stall = 1'b0;
    logic [511:0] rx_data_o;
    logic [3:0]   rx_ena_o, rx_sop_o, rx_eop_o, rx_err_o;
    logic [15:0]  rx_mty_o;
    logic [31:0]  rec_f [4];
    logic [127:0] rec_d;
    int           rec_n = 0, fail_count = 0, checked = 0;
    spb_bus_if dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .tx_data_i(tx_data_i), .tx_ena_i(tx_ena_i), .tx_sop_i(tx_sop_i),
        .tx_eop_i(tx_eop_i), .tx_err_i(tx_err_i), .tx_mty_i(tx_mty_i),
        .tx_rdy_o(tx_rdy_o), .tx_ovf_o(tx_ovf_o),
        .ln_tx_valid_o(ln_tx_valid_o), .ln_tx_data_o(ln_tx_data_o),
        .ln_tx_sop_o(ln_tx_sop_o), .ln_tx_eop_o(ln_tx_eop_o),
        .ln_tx_mty_o(ln_tx_mty_o), .ln_tx_ready_i(ln_tx_ready_i),
        .ln_rx_valid_i(ln_rx_valid_i), .ln_rx_data_i(ln_rx_data_i),
        .ln_rx_sop_i(ln_rx_sop_i), .ln_rx_eop_i(ln_rx_eop_i),
        .ln_rx_mty_i(ln_rx_mty_i), .ln_rx_code_bad_i(ln_rx_code_bad_i),
        .ln_rx_fcs_bad_i(ln_rx_fcs_bad_i), .rx_data_o(rx_data_o),
        .rx_ena_o(rx_ena_o), .rx_sop_o(rx_sop_o), .rx_eop_o(rx_eop_o),
        .rx_err_o(rx_err_o), .rx_mty_o(rx_mty_o));
    spb_line_model u_line (.clk_i(clk_i), .stall_i(stall),
        .valid_i(ln_tx_valid_o), .data_i(ln_tx_data_o), .sop_i(ln_tx_sop_o),
        .eop_i(ln_tx_eop_o), .mty_i(ln_tx_mty_o), .ready_o(ln_tx_ready_i),
        .rx_valid_o(ln_rx_valid_i), .rx_data_o(ln_rx_data_i),
        .rx_sop_o(ln_rx_sop_i), .rx_eop_o(ln_rx_eop_i),
        .rx_mty_o(ln_rx_mty_i), .rx_code_bad_o(ln_rx_code_bad_i),
        .rx_fcs_bad_o(ln_rx_fcs_bad_i));
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (rx_ena_o !== 4'h0 && rec_n < 4) begin
            rec_f[rec_n] = {rx_ena_o, rx_sop_o, rx_eop_o, rx_err_o, rx_mty_o};
            if (rec_n == 0) rec_d = rx_data_o[255:128];
            rec_n++;
        end
    end
    // ************
    // tasks and scenarios
    // ************
    task automatic chk(input string n, input logic [511:0] e,
                       input logic [511:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] en, s, eo, er, input logic [15:0] m);
        @(posedge clk_i);
        #1;
        {tx_ena_i, tx_sop_i, tx_eop_i, tx_err_i, tx_mty_i} = {en, s, eo, er, m};
    endtask : wr
    task automatic rst();
        sys_rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        chk("reset ready", 0, tx_rdy_o);
        sys_rst_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk("ready", 1, tx_rdy_o);
        chk("overflow", 0, tx_ovf_o);
    endtask : rst
    task automatic t_tx(input logic [3:0] er);
        int n0;
        n0 = u_line.taken;
        stall = 1'b1;
        wr(4'hf, 4'h1, 4'h0, 4'h0, 16'h0);
        wr(4'h3, 4'h0, 4'h2, er, 16'h0070);
        wr(4'hf, 4'h1, 4'h8, 4'h0, 16'h0);
        wr(4'h0, 4'h0, 4'h0, 4'h0, 16'h0);
        repeat (4) @(posedge clk_i);
        #1;
        stall = 1'b0;
        repeat (60) @(posedge clk_i);
        #1;
        chk("words", er ? 4 : 10, u_line.taken - n0);
        chk("last word", {6'h10, P}, u_line.last);
    endtask : t_tx
    task automatic t_rx(input int nw, input logic [1:0] bad);
        int e;
        logic er;
        e = (nw - 1) % 4;
        er = (bad != 2'b00) || nw < 4;
        rec_n = 0;
        for (int j = 0; j < nw; j++) begin
            u_line.send({16{8'(j + 1)}}, j == 0, j == nw - 1,
                        j == nw - 1 ? 4'ha : 4'h0, j == nw - 1 ? bad : 2'b0);
        end
        u_line.idle();
        repeat (4) @(posedge clk_i);
        #1;
        chk("rx cycles", (nw + 3) / 4, rec_n);
        chk("rx end", {4'((1 << (e + 1)) - 1), 4'(nw <= 4), 4'(1 << e),
            4'(er) << e, 16'(er ? 4'h8 : 4'ha) << (4 * e)}, rec_f[rec_n - 1]);
        if (nw > 4) chk("rx first", 32'hf1000000, rec_f[0]);
        chk("rx order", {16{8'h02}}, rec_d);
    endtask : t_rx
    task automatic t_ovf();
        int n;
        n = 0;
        stall = 1'b1;
        do begin
            wr(4'hf, 4'h1, 4'h8, 4'h0, 16'h0);
            n++;
        end while (tx_rdy_o === 1'b1 && n < 400);
        repeat (7) wr(4'hf, 4'h1, 4'h8, 4'h0, 16'h0);
        wr(4'h0, 4'h0, 4'h0, 4'h0, 16'h0);
        repeat (3) @(posedge clk_i);
        #1;
        chk("safe late writes", 0, tx_ovf_o);
        repeat (3) wr(4'hf, 4'h1, 4'h8, 4'h0, 16'h0);
        wr(4'h0, 4'h0, 4'h0, 4'h0, 16'h0);
        repeat (3) @(posedge clk_i);
        #1;
        chk("overflow set", 1, tx_ovf_o);
        stall = 1'b0;
        rst();
    endtask : t_ovf
    // ************
    // run control
    // ************
    task automatic final_report();
        $display("checks %0d failures %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        #400000;
        fail_count++;
        final_report();
    end
    initial begin
        rst();
        t_tx(4'h0);
        t_tx(4'h2);
        t_rx(5, 2'b01);
        t_rx(5, 2'b10);
        t_rx(3, 2'b00);
        t_rx(5, 2'b00);
        t_ovf();
        final_report();
    end
endmodule : tb_top
bind spb_bus_if spb_props u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .tx_ena_i(tx_ena_i), .tx_rdy_o(tx_rdy_o), .tx_ovf_o(tx_ovf_o),
    .ln_tx_valid_o(ln_tx_valid_o), .ln_tx_data_o(ln_tx_data_o),
    .ln_tx_eop_o(ln_tx_eop_o), .ln_tx_mty_o(ln_tx_mty_o),
    .ln_tx_ready_i(ln_tx_ready_i), .rx_ena_o(rx_ena_o), .rx_sop_o(rx_sop_o),
    .rx_eop_o(rx_eop_o), .rx_err_o(rx_err_o), .rx_mty_o(rx_mty_o));
